//--- dag_pkg.sv
// Constants, field layouts and request codes for the data address generator.
// Assumes one core clock domain; the decoder and the RAM share it.
package dag_pkg;

    // Address widths of the data and program spaces.
    localparam int DAG_ADDR_W = 12;
    localparam int DAG_FILE_W = 8;
    localparam int DAG_BANK_W = 4;
    localparam int DAG_TGT_W = 20;

    // Fixed access window: low part maps to bank 0, high part to the top bank.
    localparam logic [7:0] DAG_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] DAG_ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] DAG_ACCESS_HIGH_BANK = 4'hf;

    // Register byte offsets on the Avalon-MM slave (word index times four).
    localparam logic [4:0] DAG_REG_BANK = 5'h00;
    localparam logic [4:0] DAG_REG_CFG = 5'h04;
    localparam logic [4:0] DAG_REG_STATUS = 5'h08;
    localparam logic [4:0] DAG_REG_PTR0 = 5'h10;
    localparam int DAG_PTR_STRIDE = 4;

    // Field positions inside the registers.
    localparam int DAG_CFG_EXT_BIT = 0;
    localparam int DAG_STS_FAULT_BIT = 12;
    localparam int DAG_STS_FILE_BIT = 13;

    // Reset values, and the read value of unmapped offsets.
    localparam logic [3:0] DAG_BANK_RST = 4'h0;
    localparam logic [11:0] DAG_PTR_RST = 12'h000;
    localparam logic [31:0] DAG_UNMAPPED_DATA = 32'h0000_0000;

    // Addressing mode of one decoded instruction, one-hot.
    typedef enum logic [5:0] {
        DAG_K_INHERENT = 6'b000001,
        DAG_K_LITERAL = 6'b000010,
        DAG_K_DIRECT = 6'b000100,
        DAG_K_FULL = 6'b001000,
        DAG_K_INDIRECT = 6'b010000,
        DAG_K_INDEXED = 6'b100000
    } dag_kind_t;

    // Pointer side effect of an indirect access, one-hot.
    typedef enum logic [4:0] {
        DAG_I_PLAIN = 5'b00001,
        DAG_I_POSTINC = 5'b00010,
        DAG_I_POSTDEC = 5'b00100,
        DAG_I_PREINC = 5'b01000,
        DAG_I_PLUSOFF = 5'b10000
    } dag_ind_t;

endpackage : dag_pkg

//--- dag_ram_model.sv
// Behavioural model of the banked data RAM beside the address generator.
// Assumes the generator's registered outputs and one core clock.
`timescale 1ns/1ps
`default_nettype none
module dag_ram_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Address and destination from the generator.
    input wire logic addr_valid,
    input wire logic [11:0] data_addr,
    input wire logic uses_data,
    input wire logic dest_file,
    // Count of results written back to a file register.
    output int wr_count
);
    // file write back. Only file destinations count as a write.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_count <= 0;
        end else if (addr_valid && uses_data && dest_file) begin
            wr_count <= wr_count + 1;
        end
    end
endmodule : dag_ram_model
`default_nettype wire

//--- dag_top.sv
// Data address generator of an 8-bit core: forms operand and destination
// addresses from decoded opcode fields and keeps the bank and pointer state.
// Assumes the decoder drives its request on the core clock and that
// software reaches the registers over an Avalon-MM slave with waitrequest.
// Behaviour
// - Program memory only through the PC; data via several addressing modes.
// - Indexed literal offset mode works only when extended set is enabled.
// - Inherent instructions have no operand; act globally or on implied register.
// - Literal operand comes from opcode; call and jump carry 20-bit target.
// - Byte and bit instructions carry 8-bit file address in low byte.
// - Access bit one combines bank select with opcode byte into 12 bits.
// - Access bit zero ignores bank select and maps onto access window.
// - File-to-file move uses full 12-bit address, ignoring bank select.
// - Destination bit one writes result back to the source file register.
// - Destination bit zero writes result to working register, file untouched.
// - Instructions without destination bit use their fixed implied destination.
// - Pointers serve as indirect addresses and are directly readable, writable.
// - Indirect accesses can post-increment, post-decrement or pre-increment the pointer, or offset the address.
`timescale 1ns/1ps
`default_nettype none

module dag_top #(
    parameter int NUM_PTR = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM register slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Decoded instruction from the decoder.
    input wire logic req_valid,
    input wire dag_pkg::dag_kind_t req_kind,
    input wire logic [7:0] req_file_addr,
    input wire logic req_access_bit,
    input wire logic req_has_dest,
    input wire logic req_dest_bit,
    input wire logic req_implied_file,
    input wire logic [11:0] req_full_addr,
    input wire logic [19:0] req_target,
    input wire logic [1:0] req_ptr_sel,
    input wire dag_pkg::dag_ind_t req_ind_mode,
    input wire logic [7:0] req_offset,
    // Address and destination towards the data RAM.
    output logic addr_valid,
    output logic [11:0] data_addr,
    output logic uses_data,
    output logic dest_file,
    output logic dest_working,
    output logic [7:0] literal_value,
    output logic [19:0] program_target,
    output logic mode_fault
);
    import dag_pkg::*;

    // The pointer select is two bits wide, so four pointers at most.
    if (NUM_PTR < 1 || NUM_PTR > 4) begin : g_num_ptr_check
        $error("NUM_PTR must lie between 1 and 4.");
    end

    typedef struct packed {
        logic [3:0] bank;
        logic ext_en;
        logic [NUM_PTR-1:0][11:0] ptr;
        logic ack;
        logic [31:0] rdata;
        logic addr_valid;
        logic [11:0] addr;
        logic uses_data;
        logic dest_file;
        logic dest_working;
        logic [7:0] literal;
        logic [19:0] target;
        logic fault;
    } dag_state_t;

    dag_state_t state_q;
    dag_state_t state_d;

    // Folds an opcode byte into the fixed access window.
    function automatic logic [11:0] dag_window(input logic [7:0] fa);
        if (fa < DAG_ACCESS_SPLIT) begin
            dag_window = {DAG_ACCESS_LOW_BANK, fa};
        end else begin
            dag_window = {DAG_ACCESS_HIGH_BANK, fa};
        end
    endfunction : dag_window

    // Decodes a bus offset into a pointer index, or NUM_PTR when none hits.
    function automatic int dag_ptr_hit(input logic [4:0] a);
        dag_ptr_hit = NUM_PTR;
        for (int i = 0; i < NUM_PTR; i++) begin
            if (a == 5'(int'(DAG_REG_PTR0) + i * DAG_PTR_STRIDE)) begin
                dag_ptr_hit = i;
            end
        end
    endfunction : dag_ptr_hit

    // Avalon slave and address formation share one next-state process.
    always_comb begin
        logic [11:0] sel_ptr;
        logic [11:0] off_ext;
        int hit;
        int psel;
        state_d = state_q;
        sel_ptr = '0;
        off_ext = {4'h0, req_offset};
        hit = dag_ptr_hit(avs_address);
        psel = int'(req_ptr_sel);

        // The answer comes one cycle after the request; ack drops after.
        // A request held through the answer edge is not taken a second time.
        state_d.ack = (avs_read || avs_write) && !state_q.ack;
        if (avs_read && !state_q.ack) begin
            state_d.rdata = DAG_UNMAPPED_DATA;
            case (avs_address)
                DAG_REG_BANK: begin
                    state_d.rdata[3:0] = state_q.bank;
                end
                DAG_REG_CFG: begin
                    state_d.rdata[DAG_CFG_EXT_BIT] = state_q.ext_en;
                end
                DAG_REG_STATUS: begin
                    state_d.rdata[11:0] = state_q.addr;
                    state_d.rdata[DAG_STS_FAULT_BIT] = state_q.fault;
                    state_d.rdata[DAG_STS_FILE_BIT] = state_q.dest_file;
                end
                default: begin
                    if (hit < NUM_PTR) begin
                        state_d.rdata[11:0] = state_q.ptr[hit];
                    end
                end
            endcase
        end

        // Writes take effect on the edge at which the master sees waitrequest
        // low, so a write lands exactly once, where the bus says it does, unless an indirect access to that pointer wins at that edge.
        // The master still holds address, data and lanes at that edge.
        if (avs_write && state_q.ack) begin
            case (avs_address)
                DAG_REG_BANK: begin
                    if (avs_byteenable[0]) begin
                        state_d.bank = avs_writedata[3:0];
                    end
                end
                DAG_REG_CFG: begin
                    if (avs_byteenable[0]) begin
                        state_d.ext_en = avs_writedata[DAG_CFG_EXT_BIT];
                    end
                end
                default: begin
                    if (hit < NUM_PTR) begin
                        if (avs_byteenable[0]) begin
                            state_d.ptr[hit][7:0] = avs_writedata[7:0];
                        end
                        if (avs_byteenable[1]) begin
                            state_d.ptr[hit][11:8] = avs_writedata[11:8];
                        end
                    end
                end
            endcase
        end

        // Results stand until the next request replaces them.
        // Only addr_valid pulses, so the RAM side may latch the rest late.
        state_d.addr_valid = 1'b0;
        if (req_valid) begin
            state_d.addr_valid = 1'b1;
            state_d.fault = 1'b0;
            state_d.uses_data = 1'b0;
            state_d.dest_file = 1'b0;
            state_d.dest_working = 1'b0;
            state_d.addr = '0;
            if (psel < NUM_PTR) begin
                sel_ptr = state_q.ptr[psel];
            end
            case (req_kind)
                DAG_K_INHERENT: begin
                    state_d.dest_file = req_implied_file;
                    state_d.dest_working = !req_implied_file;
                end
                DAG_K_LITERAL: begin
                    state_d.literal = req_file_addr;
                    state_d.target = req_target;
                    state_d.dest_working = 1'b1;
                end
                DAG_K_DIRECT: begin
                    state_d.uses_data = 1'b1;
                    if (req_access_bit) begin
                        state_d.addr = {state_q.bank, req_file_addr};
                    end else begin
                        state_d.addr = dag_window(req_file_addr);
                    end
                end
                DAG_K_FULL: begin
                    state_d.uses_data = 1'b1;
                    state_d.addr = req_full_addr;
                end
                DAG_K_INDIRECT: begin
                    state_d.uses_data = 1'b1;
                    state_d.fault = psel >= NUM_PTR;
                    case (req_ind_mode)
                        DAG_I_PREINC: begin
                            state_d.addr = sel_ptr + 12'h001;
                        end
                        DAG_I_PLUSOFF: begin
                            state_d.addr = sel_ptr + off_ext;
                        end
                        default: begin
                            state_d.addr = sel_ptr;
                        end
                    endcase
                    // pointer side effect, wins over a bus write
                    if (psel < NUM_PTR) begin
                        case (req_ind_mode)
                            DAG_I_POSTINC: begin
                                state_d.ptr[psel] = sel_ptr + 12'h001;
                            end
                            DAG_I_POSTDEC: begin
                                state_d.ptr[psel] = sel_ptr - 12'h001;
                            end
                            DAG_I_PREINC: begin
                                state_d.ptr[psel] = sel_ptr + 12'h001;
                            end
                            default: begin
                                state_d.ptr[psel] = sel_ptr;
                            end
                        endcase
                    end
                end
                DAG_K_INDEXED: begin
                    if (state_q.ext_en && psel < NUM_PTR) begin
                        state_d.uses_data = 1'b1;
                        state_d.addr = sel_ptr + {4'h0, req_file_addr};
                    end else begin
                        state_d.fault = 1'b1;
                    end
                end
                default: begin
                    state_d.fault = 1'b1;
                end
            endcase
            if (req_has_dest && state_d.uses_data) begin
                state_d.dest_file = req_dest_bit;
                state_d.dest_working = !req_dest_bit;
            end else if (state_d.uses_data) begin
                state_d.dest_file = req_implied_file;
                state_d.dest_working = !req_implied_file;
            end
        end
    end

    // One register holds every piece of state; reset gives constants only.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
            state_q.bank <= DAG_BANK_RST;
            for (int i = 0; i < NUM_PTR; i++) begin
                state_q.ptr[i] <= DAG_PTR_RST;
            end
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs come straight from the state register.
    // data addresses only; the program counter lives elsewhere.
    assign avs_readdata = state_q.rdata;
    assign avs_waitrequest = !state_q.ack;
    assign addr_valid = state_q.addr_valid;
    assign data_addr = state_q.addr;
    assign uses_data = state_q.uses_data;
    assign dest_file = state_q.dest_file;
    assign dest_working = state_q.dest_working;
    assign literal_value = state_q.literal;
    assign program_target = state_q.target;
    assign mode_fault = state_q.fault;

endmodule : dag_top

`default_nettype wire

//--- dag_top_sva.sv
// Checker for the data address generator, bound to its top module.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dag_top_chk (
    // Clock, reset and bus handshake.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Decoder request.
    input wire logic req_valid,
    input wire dag_pkg::dag_kind_t req_kind,
    input wire logic [7:0] req_file_addr,
    input wire logic req_access_bit,
    input wire logic req_has_dest,
    input wire logic req_dest_bit,
    input wire logic req_implied_file,
    input wire logic [11:0] req_full_addr,
    input wire logic [19:0] req_target,
    // Results.
    input wire logic addr_valid,
    input wire logic [11:0] data_addr,
    input wire logic dest_file,
    input wire logic dest_working,
    input wire logic [7:0] literal_value,
    input wire logic [19:0] program_target,
    input wire logic mode_fault
);
    import dag_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic dir;

    // Direct requests share four antecedents.
    assign dir = req_valid && req_kind == DAG_K_DIRECT;

    property p_answer; req_valid |=> addr_valid; endproperty
    a_answer: assert property (p_answer)
        else $error("no answer after request");
    property p_quiet; !req_valid |=> !addr_valid; endproperty
    a_quiet: assert property (p_quiet)
        else $error("answer without request");
    property p_hold; !req_valid |=> $stable(data_addr) && $stable(dest_file);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed without request");
    property p_win; dir && !req_access_bit |=> data_addr ==
        {($past(req_file_addr) < DAG_ACCESS_SPLIT) ? DAG_ACCESS_LOW_BANK :
        DAG_ACCESS_HIGH_BANK, $past(req_file_addr)}; endproperty
    a_win: assert property (p_win)
        else $error("access window address wrong");
    property p_full; req_valid && req_kind == DAG_K_FULL |=>
        data_addr == $past(req_full_addr); endproperty
    a_full: assert property (p_full)
        else $error("full address wrong");
    property p_lit; req_valid && req_kind == DAG_K_LITERAL |=> dest_working
        && literal_value == $past(req_file_addr)
        && program_target == $past(req_target); endproperty
    a_lit: assert property (p_lit)
        else $error("literal result wrong");
    property p_d1; dir && req_has_dest && req_dest_bit |=>
        dest_file && !dest_working; endproperty
    a_d1: assert property (p_d1)
        else $error("file destination wrong");
    property p_d0; dir && req_has_dest && !req_dest_bit |=>
        !dest_file && dest_working && !mode_fault; endproperty
    a_d0: assert property (p_d0)
        else $error("working destination wrong");
    property p_imp; dir && !req_has_dest |=>
        dest_file == $past(req_implied_file); endproperty
    a_imp: assert property (p_imp)
        else $error("implied destination wrong");
    property p_bus; (avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest ##1 avs_waitrequest; endproperty
    a_bus: assert property (p_bus)
        else $error("bus answer timing wrong");
    c_ind: cover property (req_valid && req_kind == DAG_K_INDIRECT);
    c_fault: cover property (mode_fault);
    c_wr: cover property (avs_write && !avs_waitrequest);
endmodule : dag_top_chk
bind dag_top dag_top_chk u_chk (.clk, .reset_n, .avs_read, .avs_write,
    .avs_waitrequest, .req_valid, .req_kind, .req_file_addr, .req_access_bit,
    .req_has_dest, .req_dest_bit, .req_implied_file, .req_full_addr,
    .req_target, .addr_valid, .data_addr, .dest_file, .dest_working,
    .literal_value, .program_target, .mode_fault);
`default_nettype wire

//--- dag_top_tb.sv
// Self-checking bench for the data address generator.
// Assumes the RAM model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module dag_top_tb;
    import dag_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hf;
    logic avs_waitrequest, addr_valid, uses_data, dest_file, dest_working;
    logic mode_fault, df, req_valid = 1'b0;
    dag_kind_t req_kind = DAG_K_INHERENT, k_v = DAG_K_INHERENT;
    dag_ind_t req_ind_mode = DAG_I_PLAIN, md_v = DAG_I_PLAIN;
    logic [7:0] req_file_addr, req_offset, literal_value, rnd = 8'h3a;
    logic [7:0] fa_v = 8'h0, of_v = 8'h0;
    logic req_access_bit, req_has_dest, req_dest_bit, req_implied_file;
    logic a_v = 1'b0, hd_v = 1'b0, d_v = 1'b0, im_v = 1'b0;
    logic [11:0] req_full_addr, data_addr, ea, fu_v = 12'h0, pm [3];
    logic [19:0] req_target, program_target, tg_v = 20'h0;
    logic [1:0] req_ptr_sel, ps_v = 2'h0;
    logic [3:0] bank_v;
    int failures = 0, num_checks = 0, wr_count, exp_wr = 0;

    dag_top dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .req_valid, .req_kind, .req_file_addr, .req_access_bit, .req_has_dest,
        .req_dest_bit, .req_implied_file, .req_full_addr, .req_target,
        .req_ptr_sel, .req_ind_mode, .req_offset, .addr_valid, .data_addr,
        .uses_data, .dest_file, .dest_working, .literal_value,
        .program_target, .mode_fault);
    dag_ram_model ram (.clk, .reset_n, .addr_valid, .data_addr, .uses_data,
        .dest_file, .wr_count);

    // Free-running core clock.
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Next pseudo-random byte.
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nx

    // Expected direct address: banked, or folded into the access window.
    function automatic logic [11:0] exp_dir(input logic a,
        input logic [3:0] b, input logic [7:0] f);
        if (a)
            return {b, f};
        return {(f < DAG_ACCESS_SPLIT) ? DAG_ACCESS_LOW_BANK :
            DAG_ACCESS_HIGH_BANK, f};
    endfunction : exp_dir

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One bus cycle; the wait ends only on the answer or the watchdog.
    // At a rising edge the design's outputs still show their pre-edge values.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // One decoded instruction; results are looked at in the answer cycle.
    task automatic go();
        @(posedge clk);
        req_valid <= 1'b1;
        req_kind <= k_v;
        req_file_addr <= fa_v;
        req_access_bit <= a_v;
        req_has_dest <= hd_v;
        req_dest_bit <= d_v;
        req_implied_file <= im_v;
        req_full_addr <= fu_v;
        req_target <= tg_v;
        req_ptr_sel <= ps_v;
        req_ind_mode <= md_v;
        req_offset <= of_v;
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        chk(addr_valid, 1);
    endtask : go

    task automatic end_sim();
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // Watchdog sized well above the whole sequence.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end

    initial begin
        {req_file_addr, req_offset, req_full_addr, req_target} = '0;
        {req_access_bit, req_has_dest, req_dest_bit, req_implied_file} = '0;
        req_ptr_sel = 2'h0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        // Every word reads zero after reset, holes included.
        for (int i = 0; i < 8; i++) begin
            bus(0, 5'(i * 4), 32'h0);
            chk(rd, 0);
        end
        bus(1, 5'h1c, 32'hffff_ffff);
        bus(0, 5'h1c, 32'h0);
        chk(rd, 0);
        // A write with every lane cleared leaves the bank alone.
        avs_byteenable <= 4'h0;
        bus(1, DAG_REG_BANK, 32'h0000_000f);
        avs_byteenable <= 4'hf;
        bus(0, DAG_REG_BANK, 32'h0);
        chk(rd, 0);
        // Direct mode, window edges first, then random.
        for (int i = 0; i < 24; i++) begin
            rnd = nx(rnd);
            bank_v = rnd[3:0];
            bus(1, DAG_REG_BANK, {28'h0, bank_v});
            bus(0, DAG_REG_BANK, 32'h0);
            chk(rd, {28'h0, bank_v});
            rnd = nx(rnd);
            fa_v = (i < 4) ? 8'h5e + 8'(i) : rnd;
            {a_v, hd_v, d_v, im_v} = (i < 4) ? {1'b0, rnd[2:0]} : rnd[7:4];
            k_v = DAG_K_DIRECT;
            go();
            ea = exp_dir(a_v, bank_v, fa_v);
            df = hd_v ? d_v : im_v;
            exp_wr += int'(df);
            chk(data_addr, ea);
            chk({uses_data, dest_file, dest_working}, {1'b1, df, !df});
        end
        // Full, literal and inherent kinds in turn.
        {hd_v, d_v} = 2'b10;
        for (int j = 0; j < 9; j++) begin
            rnd = nx(rnd);
            k_v = (j % 3 == 0) ? DAG_K_FULL : (j % 3 == 1) ? DAG_K_LITERAL :
                DAG_K_INHERENT;
            {fu_v, tg_v, fa_v, im_v} = {rnd[3:0], rnd, rnd, rnd[3:0], rnd,
                rnd, rnd[0]};
            go();
            if (k_v == DAG_K_FULL)
                chk(data_addr, fu_v);
            else if (k_v == DAG_K_LITERAL)
                chk({literal_value, program_target, dest_working}, {fa_v, tg_v, 1'b1});
            else
                chk({uses_data, dest_file}, {1'b0, im_v});
        end
        // Pointers loaded, then every side effect on every pointer.
        for (int p = 0; p < 3; p++) begin
            rnd = nx(rnd);
            pm[p] = {rnd[3:0], rnd};
            bus(1, 5'(DAG_REG_PTR0 + DAG_PTR_STRIDE * p), {20'h0, pm[p]});
        end
        k_v = DAG_K_INDIRECT;
        for (int m = 0; m < 15; m++) begin
            rnd = nx(rnd);
            {ps_v, md_v, of_v} = {2'(m % 3), dag_ind_t'(5'h01 << (m % 5)), rnd};
            go();
            ea = pm[ps_v] + ((md_v == DAG_I_PREINC) ? 12'h1 :
                (md_v == DAG_I_PLUSOFF) ? {4'h0, of_v} : 12'h0);
            chk(data_addr, ea);
            if (md_v == DAG_I_POSTINC || md_v == DAG_I_PREINC)
                pm[ps_v] += 12'h1;
            else if (md_v == DAG_I_POSTDEC)
                pm[ps_v] -= 12'h1;
            bus(0, 5'(DAG_REG_PTR0 + DAG_PTR_STRIDE * ps_v), 32'h0);
            chk(rd, {20'h0, pm[ps_v]});
        end
        // Indexed mode refused until enabled, and for a missing pointer.
        {k_v, ps_v, fa_v} = {DAG_K_INDEXED, 2'h0, 8'h9c};
        go();
        chk({mode_fault, uses_data}, 2'b10);
        bus(1, DAG_REG_CFG, 32'h1);
        bus(0, DAG_REG_CFG, 32'h0);
        chk(rd, 1);
        go();
        chk({mode_fault, data_addr}, {1'b0, pm[0] + {4'h0, fa_v}});
        ps_v = 2'h3;
        go();
        chk({mode_fault, uses_data}, 2'b10);
        chk(wr_count, exp_wr);
        end_sim();
    end
endmodule : dag_top_tb
`default_nettype wire
